//--- hdl/spcd_pkg.sv
// shared constants for the sensor bus periodic command decoder
package spcd_pkg;
    // frame layout: address, command code, data, check byte
    localparam int FRAME_W = 32;
    localparam int ADDR_MSB = 31;
    localparam int ADDR_LSB = 28;
    localparam int CODE_MSB = 27;
    localparam int CODE_LSB = 24;
    localparam int CRC_W = 8;
    localparam int BODY_W = 24;
    localparam int LEN_W = 6;
    localparam logic [LEN_W-1:0] LEN_FULL = 6'h20;
    localparam logic [LEN_W-1:0] LEN_BCAST = 6'h01;
    localparam logic [LEN_W-1:0] LEN_FRAG_SMALL = 6'h02;
    localparam logic [LEN_W-1:0] LEN_FRAG_LARGE = 6'h04;
    localparam logic [3:0] GLOBAL_ADDR = 4'h0;
    // command codes
    localparam logic [3:0] CODE_ENTER_PERIODIC = 4'hB;
    localparam logic [15:0] RESERVED_CODE_MAP = 16'hF6FE;
    // check byte defaults
    localparam logic [7:0] CRC_POLY = 8'h2F;
    localparam logic [7:0] CRC_SEED = 8'hFF;
    // register indexes
    localparam int REG_ADDR_W = 8;
    localparam logic [7:0] REG_NODE_ADDRESS = 8'h00;
    localparam logic [7:0] REG_TIMING_CONFIG_TWO = 8'h01;
    localparam logic [7:0] REG_DEVICE_LOCK = 8'h02;
    localparam logic [7:0] REG_DIAG_STATUS = 8'h03;
    localparam logic [7:0] REG_ERROR_COUNT = 8'h04;
    // field positions and reset values
    localparam int TC2_DIAG_EN_BIT = 0;
    localparam int TC2_FRAG_SEL_BIT = 1;
    localparam int LOCK_INIT_BIT = 0;
    localparam int LOCK_PERIODIC_BIT = 1;
    localparam int LOCK_DIAG_BIT = 2;
    localparam logic [3:0] NODE_ADDRESS_RST = 4'h0;
    localparam logic [1:0] TIMING_CONFIG_TWO_RST = 2'h0;
    // response kinds handed to the transmitter
    localparam int KIND_W = 2;
    localparam logic [KIND_W-1:0] RSP_PERIODIC = 2'h0;
    localparam logic [KIND_W-1:0] RSP_RESERVED = 2'h1;
    localparam logic [KIND_W-1:0] RSP_ENTER = 2'h2;
    localparam logic [KIND_W-1:0] RSP_DIAG = 2'h3;
    localparam int FIFO_DEPTH = 16;
endpackage

//--- hdl/spcd_crc.sv
// serial check byte calculator, combinational over one word
`timescale 1ns/10ps
`default_nettype none
module spcd_crc
    import spcd_pkg::*;
#(
    parameter int DATA_W = 24,
    parameter logic [7:0] POLY = CRC_POLY,
    parameter logic [7:0] SEED = CRC_SEED
)
(
    input wire logic [DATA_W-1:0] data_i,
    output logic [7:0] crc_o
);
    always_comb
    begin
        logic [7:0] acc;
        acc = SEED;
        for (int i = DATA_W - 1; i >= 0; i--)
        begin
            if (acc[7] ^ data_i[i])
            begin
                acc = {acc[6:0], 1'b0} ^ POLY;
            end
            else
            begin
                acc = {acc[6:0], 1'b0};
            end
        end
        crc_o = acc;
    end
endmodule
`default_nettype wire

//--- hdl/spcd_fifo.sv
// synchronous response fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module spcd_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W:0] cnt_ff;
    logic [PTR_W-1:0] nxt_wr_ptr;
    logic [PTR_W-1:0] nxt_rd_ptr;
    logic [PTR_W:0] nxt_cnt;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_ff != (PTR_W+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rd_ptr_ff];
    assign level_o = cnt_ff;

    always_comb
    begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
        nxt_cnt = cnt_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

//--- hdl/spcd_top.sv
// command decoder for reserved, broadcast read and diagnostic fragment commands
//
// Function
// - answer reserved codes addressed to us when the check byte is good
// - reserved answer echoes address and code, data bits all zero, fresh check byte
// - reserved code for another address is ignored without answer
// - lock bit set means periodic mode, diagnostic mode added when enabled
// - periodic mode uses the same bit coding and message structure
// - without diagnostics, answer only one-bit broadcast reads of either value
// - diagnostic fragments are two or four bits, chosen by the size bit
// - with diagnostics, answer every broadcast read and fragment, nothing else
// - broadcast read or length other than the selected fragment size restarts assembly
// - diagnostic answer only for a full 32-bit valid command
// - assembled command is checked like a full frame, check byte included
// - broadcast reads get no check and always count as valid
// - in periodic mode each accepted read or fragment gets a periodic frame, except a completing valid fragment for us, which gets the diagnostic answer
// - lock bit stays set until device reset
// - diagnostics need periodic mode and enable bit; full frames off then
`timescale 1ns/10ps
`default_nettype none
module spcd_top
    import spcd_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // received command from the bit decoder
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [LEN_W-1:0] cmd_len_i,
    input wire logic [FRAME_W-1:0] cmd_data_i,
    // response requests to the transmitter
    output logic rsp_valid_o,
    input wire logic rsp_ready_i,
    output logic [KIND_W-1:0] rsp_kind_o,
    output logic [FRAME_W-1:0] rsp_frame_o,
    // register port
    input wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);
    localparam int ENTRY_W = KIND_W + FRAME_W;

    // ************************************************************
    // state
    // ************************************************************
    logic [3:0] node_address_register_ff;
    logic diag_mode_enable_ff;
    logic diag_fragment_size_select_ff;
    logic init_complete_lock_ff;
    logic [FRAME_W-1:0] asm_ff;
    logic [LEN_W-1:0] asm_cnt_ff;
    logic [7:0] err_cnt_ff;
    logic [7:0] reg_rdata_ff;
    logic [3:0] nxt_node_address;
    logic nxt_diag_mode_enable;
    logic nxt_diag_fragment_size_select;
    logic nxt_init_complete_lock;
    logic [FRAME_W-1:0] nxt_asm;
    logic [LEN_W-1:0] nxt_asm_cnt;
    logic [7:0] nxt_err_cnt;
    logic [7:0] nxt_reg_rdata;

    logic periodic_collection_mode;
    logic background_diag_mode;
    logic take;
    logic [LEN_W-1:0] frag_len;
    logic [FRAME_W-1:0] frag_asm;
    logic [LEN_W-1:0] frag_cnt;
    logic [7:0] crc_rx;
    logic [7:0] crc_asm;
    logic [7:0] crc_echo;
    logic push;
    logic [KIND_W-1:0] push_kind;
    logic [FRAME_W-1:0] push_frame;
    logic fifo_ready;
    logic [ENTRY_W-1:0] fifo_out;

    // ************************************************************
    // modes
    // ************************************************************
    assign periodic_collection_mode = init_complete_lock_ff;
    assign background_diag_mode = init_complete_lock_ff && diag_mode_enable_ff;
    assign frag_len = diag_fragment_size_select_ff ? LEN_FRAG_LARGE : LEN_FRAG_SMALL;
    assign cmd_ready_o = fifo_ready;
    assign take = cmd_valid_i && fifo_ready;

    // ************************************************************
    // check bytes
    // ************************************************************
    spcd_crc #(
        .DATA_W(BODY_W)
    ) u_crc_rx (
        .data_i(cmd_data_i[FRAME_W-1:CRC_W]),
        .crc_o(crc_rx)
    );

    spcd_crc #(
        .DATA_W(BODY_W)
    ) u_crc_asm (
        .data_i(frag_asm[FRAME_W-1:CRC_W]),
        .crc_o(crc_asm)
    );

    // answer body: echoed address and code, data bits all zero
    spcd_crc #(
        .DATA_W(BODY_W)
    ) u_crc_echo (
        .data_i({cmd_data_i[ADDR_MSB:CODE_LSB], 16'h0000}),
        .crc_o(crc_echo)
    );

    // ************************************************************
    // command decode
    // ************************************************************
    always_comb
    begin
        logic [3:0] rx_addr;
        logic [3:0] rx_code;
        logic [3:0] as_addr;
        logic [3:0] as_code;
        rx_addr = cmd_data_i[ADDR_MSB:ADDR_LSB];
        rx_code = cmd_data_i[CODE_MSB:CODE_LSB];
        frag_asm = {asm_ff[FRAME_W-5:0], cmd_data_i[3:0]};
        if (!diag_fragment_size_select_ff)
        begin
            frag_asm = {asm_ff[FRAME_W-3:0], cmd_data_i[1:0]};
        end
        frag_cnt = asm_cnt_ff + frag_len;
        as_addr = frag_asm[ADDR_MSB:ADDR_LSB];
        as_code = frag_asm[CODE_MSB:CODE_LSB];
        nxt_init_complete_lock = init_complete_lock_ff;
        nxt_asm = asm_ff;
        nxt_asm_cnt = asm_cnt_ff;
        nxt_err_cnt = err_cnt_ff;
        push = 1'b0;
        push_kind = RSP_PERIODIC;
        push_frame = cmd_data_i;
        if (take && !periodic_collection_mode)
        begin
            // full frames only while periodic collection is off
            if (cmd_len_i == LEN_FULL)
            begin
                if (crc_rx != cmd_data_i[CRC_W-1:0])
                begin
                    nxt_err_cnt = err_cnt_ff + 8'h01;
                end
                else if (rx_code == CODE_ENTER_PERIODIC)
                begin
                    if (rx_addr == node_address_register_ff)
                    begin
                        nxt_init_complete_lock = 1'b1;
                        push = 1'b1;
                        push_kind = RSP_ENTER;
                    end
                    else if (rx_addr == GLOBAL_ADDR)
                    begin
                        nxt_init_complete_lock = 1'b1;
                    end
                end
                else if (RESERVED_CODE_MAP[rx_code] &&
                         rx_addr == node_address_register_ff)
                begin
                    push = 1'b1;
                    push_kind = RSP_RESERVED;
                    push_frame = {rx_addr, rx_code, 16'h0000, crc_echo};
                end
            end
        end
        else if (take)
        begin
            // same framing in periodic mode; length and the assembled command decide the kind
            if (cmd_len_i == LEN_BCAST)
            begin
                push = 1'b1;
                push_kind = RSP_PERIODIC;
                nxt_asm = '0;
                nxt_asm_cnt = '0;
            end
            else if (background_diag_mode && cmd_len_i == frag_len)
            begin
                push = 1'b1;
                push_kind = RSP_PERIODIC;
                nxt_asm = frag_asm;
                nxt_asm_cnt = frag_cnt;
                if (frag_cnt == LEN_FULL)
                begin
                    nxt_asm = '0;
                    nxt_asm_cnt = '0;
                    if (crc_asm != frag_asm[CRC_W-1:0])
                    begin
                        nxt_err_cnt = err_cnt_ff + 8'h01;
                    end
                    else if (as_addr == node_address_register_ff &&
                             !RESERVED_CODE_MAP[as_code])
                    begin
                        push_kind = RSP_DIAG;
                        push_frame = frag_asm;
                    end
                end
            end
            else
            begin
                nxt_asm = '0;
                nxt_asm_cnt = '0;
            end
        end
    end

    // ************************************************************
    // register port
    // ************************************************************
    always_comb
    begin
        nxt_node_address = node_address_register_ff;
        nxt_diag_mode_enable = diag_mode_enable_ff;
        nxt_diag_fragment_size_select = diag_fragment_size_select_ff;
        nxt_reg_rdata = 8'h00;
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                REG_NODE_ADDRESS:
                begin
                    nxt_node_address = reg_wdata_i[3:0];
                end
                REG_TIMING_CONFIG_TWO:
                begin
                    nxt_diag_mode_enable = reg_wdata_i[TC2_DIAG_EN_BIT];
                    nxt_diag_fragment_size_select = reg_wdata_i[TC2_FRAG_SEL_BIT];
                end
                default:
                begin
                end
            endcase
        end
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                REG_NODE_ADDRESS:
                begin
                    nxt_reg_rdata = {4'h0, node_address_register_ff};
                end
                REG_TIMING_CONFIG_TWO:
                begin
                    nxt_reg_rdata[TC2_DIAG_EN_BIT] = diag_mode_enable_ff;
                    nxt_reg_rdata[TC2_FRAG_SEL_BIT] = diag_fragment_size_select_ff;
                end
                REG_DEVICE_LOCK:
                begin
                    nxt_reg_rdata[LOCK_INIT_BIT] = init_complete_lock_ff;
                    nxt_reg_rdata[LOCK_PERIODIC_BIT] = periodic_collection_mode;
                    nxt_reg_rdata[LOCK_DIAG_BIT] = background_diag_mode;
                end
                REG_DIAG_STATUS:
                begin
                    nxt_reg_rdata = {2'h0, asm_cnt_ff};
                end
                REG_ERROR_COUNT:
                begin
                    nxt_reg_rdata = err_cnt_ff;
                end
                default:
                begin
                    nxt_reg_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            node_address_register_ff <= NODE_ADDRESS_RST;
            diag_mode_enable_ff <= TIMING_CONFIG_TWO_RST[TC2_DIAG_EN_BIT];
            diag_fragment_size_select_ff <= TIMING_CONFIG_TWO_RST[TC2_FRAG_SEL_BIT];
            init_complete_lock_ff <= 1'b0;
            asm_ff <= '0;
            asm_cnt_ff <= '0;
            err_cnt_ff <= 8'h00;
            reg_rdata_ff <= 8'h00;
        end
        else
        begin
            node_address_register_ff <= nxt_node_address;
            diag_mode_enable_ff <= nxt_diag_mode_enable;
            diag_fragment_size_select_ff <= nxt_diag_fragment_size_select;
            init_complete_lock_ff <= nxt_init_complete_lock;
            asm_ff <= nxt_asm;
            asm_cnt_ff <= nxt_asm_cnt;
            err_cnt_ff <= nxt_err_cnt;
            reg_rdata_ff <= nxt_reg_rdata;
        end
    end

    assign reg_rdata_o = reg_rdata_ff;

    // ************************************************************
    // response queue
    // ************************************************************
    spcd_fifo #(
        .WIDTH(ENTRY_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(push),
        .in_ready_o(fifo_ready),
        .in_data_i({push_kind, push_frame}),
        .out_valid_o(rsp_valid_o),
        .out_ready_i(rsp_ready_i),
        .out_data_o(fifo_out),
        .level_o()
    );

    assign rsp_kind_o = fifo_out[ENTRY_W-1:FRAME_W];
    assign rsp_frame_o = fifo_out[FRAME_W-1:0];
endmodule
`default_nettype wire

//--- dv/spcd_top_properties.sv
// port-level assertions for the command decoder
`timescale 1ns/10ps
`default_nettype none
module spcd_top_properties
    import spcd_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_ready_o,
    input wire logic [LEN_W-1:0] cmd_len_i,
    input wire logic [FRAME_W-1:0] cmd_data_i,
    input wire logic rsp_valid_o,
    input wire logic rsp_ready_i,
    input wire logic [KIND_W-1:0] rsp_kind_o,
    input wire logic [FRAME_W-1:0] rsp_frame_o,
    input wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o
);
    // ************************************
    // lock tracking and checks
    // ************************************
    logic locked_ff;
    logic nxt_locked;
    logic take;
    assign take = cmd_valid_i && cmd_ready_o;
    always_comb
    begin
        nxt_locked = locked_ff;
        if (rsp_valid_o && rsp_kind_o == RSP_ENTER)
            nxt_locked = 1'b1;
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            locked_ff <= 1'b0;
        else
            locked_ff <= nxt_locked;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read answer");
    a_head_holds: assert property (
        rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_frame_o) && $stable(rsp_kind_o))
        else $error("response head dropped or changed while stalled");
    a_reserved_echo: assert property (
        rsp_valid_o && rsp_kind_o == RSP_RESERVED |-> 16'hF6FE >> rsp_frame_o[27:24] & 16'h1)
        else $error("reserved answer carries a non-reserved code");
    a_diag_valid_code: assert property (
        rsp_valid_o && rsp_kind_o == RSP_DIAG |-> !(16'hF6FE >> rsp_frame_o[27:24] & 16'h1))
        else $error("diagnostic answer for a reserved code");
    a_odd_len_silent: assert property (
        take && cmd_len_i == 6'h03 && !rsp_valid_o |=> !rsp_valid_o)
        else $error("three-bit command answered");
    a_bcast_answered: assert property (
        locked_ff && take && cmd_len_i == LEN_BCAST && !rsp_valid_o |=> rsp_valid_o
        && rsp_kind_o == RSP_PERIODIC && rsp_frame_o == $past(cmd_data_i))
        else $error("broadcast read not answered with a periodic frame");
    a_locked_no_reserved: assert property (
        locked_ff && rsp_valid_o |-> rsp_kind_o != RSP_RESERVED)
        else $error("reserved answer while periodic");
    a_unlocked_full_only: assert property (
        !locked_ff && take && cmd_len_i != LEN_FULL && !rsp_valid_o |=> !rsp_valid_o)
        else $error("short command answered before lock");
    a_lock_read_set: assert property (
        locked_ff && reg_rd_i && reg_addr_i == REG_DEVICE_LOCK |=> reg_rdata_o[LOCK_INIT_BIT])
        else $error("lock bit reads clear after lock");
endmodule
bind spcd_top spcd_top_properties #(.DEPTH(DEPTH)) u_props (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_len_i(cmd_len_i), .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
    .rsp_ready_i(rsp_ready_i), .rsp_kind_o(rsp_kind_o), .rsp_frame_o(rsp_frame_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

//--- dv/spcd_xmit_model.sv
// response taker that stalls at random or on request
`timescale 1ns/10ps
`default_nettype none
module spcd_xmit_model (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic rsp_valid_i,
    input wire logic stall_i,
    output logic rsp_ready_o
);
    always @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            rsp_ready_o <= 1'b0;
        else
            rsp_ready_o <= !stall_i && (!rsp_valid_i || $urandom_range(3) != 0);
    end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import spcd_pkg::*;
    logic clk_sys_i, rst_n_i, cmd_valid_i, cmd_ready_o, rsp_valid_o, rsp_ready_i;
    logic reg_wr_i, reg_rd_i, stall;
    logic [LEN_W-1:0] cmd_len_i;
    logic [FRAME_W-1:0] cmd_data_i, rsp_frame_o, w;
    logic [KIND_W-1:0] rsp_kind_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [33:0] expq[$];
    int mismatches, comparisons, i;
    spcd_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_len_i(cmd_len_i), .cmd_data_i(cmd_data_i),
        .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i), .rsp_kind_o(rsp_kind_o),
        .rsp_frame_o(rsp_frame_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    spcd_xmit_model partner (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .rsp_valid_i(rsp_valid_o), .stall_i(stall), .rsp_ready_o(rsp_ready_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // ************************************
    // helpers
    // ************************************
    function automatic logic [31:0] frame(input logic [3:0] a, input logic [3:0] c,
        input logic [15:0] d);
        logic [7:0] r;
        logic [23:0] b;
        r = CRC_SEED;
        b = {a, c, d};
        for (int k = 23; k >= 0; k--)
            r = {r[6:0], 1'b0} ^ ((r[7] ^ b[k]) ? CRC_POLY : 8'h00);
        return {a, c, d, r};
    endfunction
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cmd_valid_i <= 1'b0;
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk({26'h0, reg_rdata_o}, {26'h0, e});
        @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cmd_valid_i <= 1'b0;
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic cmd(input logic [5:0] l, input logic [31:0] d, input bit q,
        input logic [1:0] k, input logic [31:0] f);
        int n;
        cmd_valid_i <= 1'b1;
        cmd_len_i <= l;
        cmd_data_i <= d;
        if (q)
            expq.push_back({k, f});
        n = 0;
        do
        begin
            @(negedge clk_sys_i);
            n++;
        end while (!cmd_ready_o && n < 300);
        if (n >= 300)
        begin
            mismatches++;
            final_report;
        end
        @(posedge clk_sys_i);
    endtask
    task automatic frags(input logic [31:0] v, input int s, input logic [1:0] k);
        logic [31:0] p;
        for (int j = 0; j < 32 / s; j++)
        begin
            p = (v >> (32 - s * (j + 1))) & ((32'h1 << s) - 1);
            cmd(s[5:0], p, 1'b1, (j == 32 / s - 1) ? k : RSP_PERIODIC,
                (j == 32 / s - 1 && k == RSP_DIAG) ? v : p);
        end
    endtask
    task automatic drain;
        int n;
        cmd_valid_i <= 1'b0;
        n = 0;
        do
        begin
            @(negedge clk_sys_i);
            n++;
        end while ((expq.size() != 0 || rsp_valid_o) && n < 500);
        if (n >= 500)
        begin
            mismatches++;
            final_report;
        end
        @(posedge clk_sys_i);
    endtask
    always @(negedge clk_sys_i)
    begin
        if (rst_n_i && rsp_valid_o && rsp_ready_i)
            chk({rsp_kind_o, rsp_frame_o}, expq.size() ? expq.pop_front() : 34'h0);
    end
    // ************************************
    // main sequence
    // ************************************
    initial
    begin
        {rst_n_i, cmd_valid_i, reg_wr_i, reg_rd_i, stall} = 5'h0;
        {cmd_len_i, cmd_data_i, reg_addr_i, reg_wdata_i} = 54'h0;
        mismatches = 0;
        comparisons = 0;
        void'($urandom(32'hC883));
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(REG_DEVICE_LOCK, 8'h00);
        rd(REG_NODE_ADDRESS, {4'h0, NODE_ADDRESS_RST});
        rd(8'h7E, 8'h00);
        wr(REG_NODE_ADDRESS, 8'h05);
        for (i = 0; i < 16; i++)
        begin
            w = frame(4'h5, i[3:0], $urandom);
            if (i != 11)
                cmd(6'h20, w, 16'hF6FE >> i & 1, RSP_RESERVED, frame(4'h5, i[3:0], 16'h0));
        end
        cmd(6'h20, frame(4'h6, 4'h1, $urandom), 1'b0, RSP_PERIODIC, 0);
        cmd(6'h20, frame(4'h5, 4'h2, 16'h1234) ^ 32'h1, 1'b0, RSP_PERIODIC, 0);
        cmd(6'h01, 32'h1, 1'b0, RSP_PERIODIC, 0);
        drain;
        rd(REG_ERROR_COUNT, 8'h01);
        w = frame(4'h5, CODE_ENTER_PERIODIC, 16'h0);
        cmd(6'h20, w, 1'b1, RSP_ENTER, w);
        drain;
        rd(REG_DEVICE_LOCK, 8'h03);
        cmd(6'h20, frame(4'h5, 4'h1, 16'h0), 1'b0, RSP_PERIODIC, 0);
        for (i = 0; i < 2; i++)
            cmd(6'h01, i, 1'b1, RSP_PERIODIC, i);
        cmd(6'h02, 32'h2, 1'b0, RSP_PERIODIC, 0);
        cmd(6'h03, 32'h5, 1'b0, RSP_PERIODIC, 0);
        wr(REG_TIMING_CONFIG_TWO, 8'h01);
        rd(REG_DEVICE_LOCK, 8'h07);
        w = frame(4'h5, 4'h0, $urandom);
        frags(w, 2, RSP_DIAG);
        wr(REG_TIMING_CONFIG_TWO, 8'h03);
        for (i = 0; i < 3; i++)
            cmd(6'h04, {28'h0, w[31-4*i -: 4]}, 1'b1, RSP_PERIODIC, {28'h0, w[31-4*i -: 4]});
        rd(REG_DIAG_STATUS, 8'h0C);
        cmd(6'h01, 32'h0, 1'b1, RSP_PERIODIC, 32'h0);
        frags(w ^ 32'h1, 4, RSP_PERIODIC);
        frags(w, 4, RSP_DIAG);
        drain;
        rd(REG_ERROR_COUNT, 8'h02);
        stall <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        for (i = 0; i < 16; i++)
            cmd(6'h01, i & 1, 1'b1, RSP_PERIODIC, i & 1);
        cmd_valid_i <= 1'b0;
        @(negedge clk_sys_i);
        chk({33'h0, cmd_ready_o}, 34'h0);
        @(posedge clk_sys_i);
        stall <= 1'b0;
        drain;
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        rd(REG_DEVICE_LOCK, 8'h00);
        cmd(6'h01, 32'h1, 1'b0, RSP_PERIODIC, 0);
        drain;
        wr(REG_NODE_ADDRESS, 8'h05);
        cmd(6'h20, frame(GLOBAL_ADDR, CODE_ENTER_PERIODIC, 16'h0), 1'b0, RSP_PERIODIC, 0);
        drain;
        rd(REG_DEVICE_LOCK, 8'h03);
        final_report;
    end
endmodule
`default_nettype wire
